/* core/clock_synth_consts.vh */
// Offsets, field positions, reset values and phase codes of the clock synthesizer bank
`ifndef CLOCK_SYNTH_CONSTS_VH
`define CLOCK_SYNTH_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define INPUT_INVERSION_CTRL_ADDR 7'h00
`define SPREAD_STEP_CTRL_ADDR     7'h04
`define LOOP_FILTER_CTRL_ADDR     7'h4F
`define STARTUP_ENABLE_CTRL_ADDR  7'h73

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define INV_FEEDBACK_BIT   3
`define INV_REF_B_BIT      2
`define INV_REF_A_BIT      1
`define SPREAD_START_MSB   5
`define SPREAD_START_LSB   3
`define SPREAD_STEP_MSB    2
`define SPREAD_STEP_LSB    0
`define RES_BIT3           15
`define RES_BIT2           12
`define RES_BIT1           11
`define RES_BIT0           8
`define HF_CAP_BIT1        7
`define HF_CAP_BIT0        4
`define TRISTATE_WAIT_BIT  15
`define STARTUP_WAIT_BIT   14
`define LOOP_ENABLE_BIT    12

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPREAD_START_RESET 3'h4
`define SPREAD_STEP_RESET  3'h7
`define LOOP_ENABLE_RESET  1'h1

// ----------------------------------------------------------------
// Fractional divider VCO phase codes
// ----------------------------------------------------------------
`define FRAC_PHASE_A       3'h0
`define FRAC_PHASE_B_START 3'h2
`define FRAC_PHASE_B_STEP  3'h2

`endif

/* core/clock_synth_reconfig_regs.v */
// Reconfiguration register bank of the clock synthesizer
// Overview of operation
// - In fractional 2.125 mode counter A runs on VCO phase 0 and counter B starts on phase 2.
// - The output rises on counter A, falls on B's second edge, rises on B's next edge as B steps.
// - Spread register bits 5:3 hold the start step count, reset value 100.
// - Spread register bits 2:0 hold the spread step count, reset value 111.
// - Bit 2 of register 0x00 inverts the second reference clock input.
// - Bit 1 of register 0x00 inverts the first reference clock input.
// - Register 0x00 bits act exactly like the matching static inversion attributes.
// - The simpler loop exposes only the reduced register set.
// - With register 0x73 bit 15 set, lock detection waits for the tristate release.
// - With register 0x73 bit 14 set, start-up stalls until the loop reports lock.
// - Register 0x4F bits 15, 12, 11, 8 form the four-bit loop filter resistor setting.
// - Register 0x4F bits 7 and 4 form the two-bit high-frequency capacitor setting.
// - The fractional divider runs only when counter and fractional enables are both set.
`timescale 1ns/100ps
`default_nettype none
`include "clock_synth_consts.vh"

module clock_synth_reconfig_regs
#(
    parameter REF_A_INVERTED_ATTR    = 1'b0,
    parameter REF_B_INVERTED_ATTR    = 1'b0,
    parameter FEEDBACK_INVERTED_ATTR = 1'b0
)
(
    input  wire        clk_in,
    input  wire        rstn_in,
    input  wire        cfg_en_in,
    input  wire        cfg_we_in,
    input  wire [6:0]  cfg_addr_in,
    input  wire [15:0] cfg_wdata_in,
    output reg  [15:0] cfg_rdata_out,
    output reg         cfg_ready_out,
    input  wire        global_tristate_release_in,
    input  wire        lock_indicator_in,
    input  wire        counter_enable_in,
    input  wire        fractional_enable_in,
    input  wire        edge_a_in,
    input  wire        edge_b_in,
    output reg         invert_ref_input_a_out,
    output reg         invert_ref_input_b_out,
    output reg         invert_feedback_input_out,
    output reg  [2:0]  spread_start_step_count_out,
    output reg  [2:0]  spread_step_count_out,
    output reg  [3:0]  loop_filter_resistor_out,
    output reg  [1:0]  loop_filter_hf_cap_out,
    output reg         loop_enable_out,
    output reg         lock_detect_start_out,
    output reg         startup_stall_out,
    output wire        frac_clk_out,
    output wire [2:0]  phase_a_out,
    output wire [2:0]  phase_b_out,
    output wire        frac_active_out
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    reg [2:0] inv_q;        // Feedback, ref B, ref A
    reg [2:0] start_step_q;
    reg [2:0] step_q;
    reg [3:0] res_q;
    reg [1:0] hf_cap_q;
    reg       tristate_wait_q;
    reg       startup_wait_q;
    reg       loop_enable_q;

    // Address match, used by the write path and the read path
    function hit;
        input [6:0] addr;
        input [6:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire [1:0] pin_raw;
    wire [1:0] pin_stable;

    assign pin_raw = {lock_indicator_in, global_tristate_release_in};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg agree_q;
            assign pin_stable[g] = agree_q;
            always @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    s1_q    <= 1'b0;
                    s2_q    <= 1'b0;
                    s3_q    <= 1'b0;
                    agree_q <= 1'b0;
                end
                else
                begin
                    s1_q <= pin_raw[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // A change counts only once two stages agree
                    if (s2_q == s3_q)
                        agree_q <= s3_q;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Write path
    // ----------------------------------------------------------------
    wire wr;

    assign wr = cfg_en_in & cfg_we_in;

    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            inv_q           <= 3'h0;
            start_step_q    <= `SPREAD_START_RESET;
            step_q          <= `SPREAD_STEP_RESET;
            res_q           <= 4'h0;
            hf_cap_q        <= 2'h0;
            tristate_wait_q <= 1'b0;
            startup_wait_q  <= 1'b0;
            loop_enable_q   <= `LOOP_ENABLE_RESET;
        end
        else if (wr)
        begin
            if (hit(cfg_addr_in, `INPUT_INVERSION_CTRL_ADDR))
                inv_q <= cfg_wdata_in[`INV_FEEDBACK_BIT:`INV_REF_A_BIT];
            if (hit(cfg_addr_in, `SPREAD_STEP_CTRL_ADDR))
            begin
                start_step_q <= cfg_wdata_in[`SPREAD_START_MSB:`SPREAD_START_LSB];
                step_q       <= cfg_wdata_in[`SPREAD_STEP_MSB:`SPREAD_STEP_LSB];
            end
            if (hit(cfg_addr_in, `LOOP_FILTER_CTRL_ADDR))
            begin
                res_q    <= {cfg_wdata_in[`RES_BIT3], cfg_wdata_in[`RES_BIT2],
                             cfg_wdata_in[`RES_BIT1], cfg_wdata_in[`RES_BIT0]};
                hf_cap_q <= {cfg_wdata_in[`HF_CAP_BIT1], cfg_wdata_in[`HF_CAP_BIT0]};
            end
            if (hit(cfg_addr_in, `STARTUP_ENABLE_CTRL_ADDR))
            begin
                tristate_wait_q <= cfg_wdata_in[`TRISTATE_WAIT_BIT];
                startup_wait_q  <= cfg_wdata_in[`STARTUP_WAIT_BIT];
                loop_enable_q   <= cfg_wdata_in[`LOOP_ENABLE_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Only the reduced set decodes; every other address reads as zero
    reg [15:0] rdata;

    always @*
    begin
        rdata = 16'h0000;
        if (hit(cfg_addr_in, `INPUT_INVERSION_CTRL_ADDR))
            rdata[`INV_FEEDBACK_BIT:`INV_REF_A_BIT] = inv_q;
        else if (hit(cfg_addr_in, `SPREAD_STEP_CTRL_ADDR))
            rdata[`SPREAD_START_MSB:`SPREAD_STEP_LSB] = {start_step_q, step_q};
        else if (hit(cfg_addr_in, `LOOP_FILTER_CTRL_ADDR))
        begin
            rdata[`RES_BIT3]    = res_q[3];
            rdata[`RES_BIT2]    = res_q[2];
            rdata[`RES_BIT1]    = res_q[1];
            rdata[`RES_BIT0]    = res_q[0];
            rdata[`HF_CAP_BIT1] = hf_cap_q[1];
            rdata[`HF_CAP_BIT0] = hf_cap_q[0];
        end
        else if (hit(cfg_addr_in, `STARTUP_ENABLE_CTRL_ADDR))
        begin
            rdata[`TRISTATE_WAIT_BIT] = tristate_wait_q;
            rdata[`STARTUP_WAIT_BIT]  = startup_wait_q;
            rdata[`LOOP_ENABLE_BIT]   = loop_enable_q;
        end
    end

    // Every access, mapped or not, is answered one cycle later
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cfg_rdata_out <= 16'h0000;
            cfg_ready_out <= 1'b0;
        end
        else
        begin
            cfg_ready_out <= cfg_en_in;
            if (cfg_en_in && !cfg_we_in)
                cfg_rdata_out <= rdata;
        end
    end

    // ----------------------------------------------------------------
    // Control outputs
    // ----------------------------------------------------------------
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            invert_ref_input_a_out      <= 1'b0;
            invert_ref_input_b_out      <= 1'b0;
            invert_feedback_input_out   <= 1'b0;
            spread_start_step_count_out <= `SPREAD_START_RESET;
            spread_step_count_out       <= `SPREAD_STEP_RESET;
            loop_filter_resistor_out    <= 4'h0;
            loop_filter_hf_cap_out      <= 2'h0;
            loop_enable_out             <= 1'b0;
            lock_detect_start_out       <= 1'b0;
            startup_stall_out           <= 1'b0;
        end
        else
        begin
            // Register bit and attribute are ORed, so either one alone inverts
            invert_ref_input_a_out    <= inv_q[0] | REF_A_INVERTED_ATTR;
            invert_ref_input_b_out    <= inv_q[1] | REF_B_INVERTED_ATTR;
            invert_feedback_input_out <= inv_q[2] | FEEDBACK_INVERTED_ATTR;
            spread_start_step_count_out <= start_step_q;
            spread_step_count_out       <= step_q;
            loop_filter_resistor_out    <= res_q;
            loop_filter_hf_cap_out      <= hf_cap_q;
            loop_enable_out             <= loop_enable_q;
            lock_detect_start_out <= loop_enable_q &
                                     (~tristate_wait_q | pin_stable[0]);
            startup_stall_out     <= startup_wait_q & ~pin_stable[1];
        end
    end

    // ----------------------------------------------------------------
    // Fractional divider
    // ----------------------------------------------------------------
    frac_phase_sequencer u_frac
    (
        .clk_in               (clk_in),
        .rstn_in              (rstn_in),
        .counter_enable_in    (counter_enable_in),
        .fractional_enable_in (fractional_enable_in),
        .edge_a_in            (edge_a_in),
        .edge_b_in            (edge_b_in),
        .frac_clk_out         (frac_clk_out),
        .phase_a_out          (phase_a_out),
        .phase_b_out          (phase_b_out),
        .frac_active_out      (frac_active_out)
    );

endmodule // clock_synth_reconfig_regs
`default_nettype wire

/* core/frac_phase_sequencer.v */
// Fractional output divider sequencer for the 2.125 ratio
`timescale 1ns/100ps
`default_nettype none
`include "clock_synth_consts.vh"

module frac_phase_sequencer
(
    input  wire       clk_in,
    input  wire       rstn_in,
    input  wire       counter_enable_in,
    input  wire       fractional_enable_in,
    input  wire       edge_a_in,
    input  wire       edge_b_in,
    output reg        frac_clk_out,
    output reg  [2:0] phase_a_out,
    output reg  [2:0] phase_b_out,
    output reg        frac_active_out
);

    // ----------------------------------------------------------------
    // One-hot states
    // ----------------------------------------------------------------
    localparam [3:0] ST_IDLE   = 4'h1;
    localparam [3:0] ST_WAIT_A = 4'h2;
    localparam [3:0] ST_FIRST  = 4'h4;
    localparam [3:0] ST_SECOND = 4'h8;

    reg  [3:0] state_q;
    reg  [3:0] state_d;
    wire       active;

    assign active = counter_enable_in & fractional_enable_in;

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:   state_d = ST_WAIT_A;
            ST_WAIT_A: if (edge_a_in) state_d = ST_FIRST;
            ST_FIRST:  if (edge_b_in) state_d = ST_SECOND;
            ST_SECOND: if (edge_b_in) state_d = ST_FIRST;
            default:   state_d = ST_IDLE;
        endcase
    end

    // Output rises on counter A, falls on the second B edge, rises on the next B edge
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_q         <= ST_IDLE;
            frac_clk_out    <= 1'b0;
            phase_a_out     <= 3'h0;
            phase_b_out     <= 3'h0;
            frac_active_out <= 1'b0;
        end
        else if (!active)
        begin
            // Disabling drops the sequence so a re-enable starts cleanly on counter A
            state_q         <= ST_IDLE;
            frac_clk_out    <= 1'b0;
            phase_a_out     <= `FRAC_PHASE_A;
            phase_b_out     <= `FRAC_PHASE_B_START;
            frac_active_out <= 1'b0;
        end
        else
        begin
            state_q         <= state_d;
            frac_active_out <= 1'b1;
            phase_a_out     <= `FRAC_PHASE_A;
            if (state_q == ST_IDLE)
                phase_b_out <= `FRAC_PHASE_B_START;
            if (state_q == ST_WAIT_A && edge_a_in)
                frac_clk_out <= 1'b1;
            if (state_q == ST_SECOND && edge_b_in)
                frac_clk_out <= 1'b0;
            if (state_q == ST_FIRST && edge_b_in && frac_clk_out == 1'b0)
            begin
                frac_clk_out <= 1'b1;
                phase_b_out  <= phase_b_out + `FRAC_PHASE_B_STEP;
            end
        end
    end

endmodule // frac_phase_sequencer
`default_nettype wire

/* verif/clock_synth_reconfig_regs_chk.sv */
// Concurrent checks on the ports of the clock synthesizer register bank
`timescale 1ns/100ps
`default_nettype none
module clock_synth_reconfig_regs_chk
(
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic        cfg_en_in,
    input wire logic        cfg_we_in,
    input wire logic [6:0]  cfg_addr_in,
    input wire logic [15:0] cfg_wdata_in,
    input wire logic        cfg_ready_out,
    input wire logic        global_tristate_release_in,
    input wire logic        lock_indicator_in,
    input wire logic        counter_enable_in,
    input wire logic        fractional_enable_in,
    input wire logic        invert_ref_input_a_out,
    input wire logic        invert_ref_input_b_out,
    input wire logic [2:0]  spread_start_step_count_out,
    input wire logic [2:0]  spread_step_count_out,
    input wire logic [3:0]  loop_filter_resistor_out,
    input wire logic [1:0]  loop_filter_hf_cap_out,
    input wire logic        loop_enable_out,
    input wire logic        lock_detect_start_out,
    input wire logic        startup_stall_out,
    input wire logic        frac_clk_out,
    input wire logic [2:0]  phase_a_out,
    input wire logic [2:0]  phase_b_out,
    input wire logic        frac_active_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // ----------------------------------------------------------------
    // Write taken, answered, then fields move one edge later
    // ----------------------------------------------------------------
    sequence s_wr(logic [6:0] a);
        cfg_en_in && cfg_we_in && cfg_addr_in == a;
    endsequence
    a_spread_start_field: assert property (
        s_wr(7'h04) |=> ##1 spread_start_step_count_out == $past(cfg_wdata_in[5:3], 2))
        else $error("spread start field mismatch");
    a_spread_step_field: assert property (
        s_wr(7'h04) |=> ##1 spread_step_count_out == $past(cfg_wdata_in[2:0], 2))
        else $error("spread step field mismatch");
    a_ref_b_invert: assert property (
        s_wr(7'h00) |=> ##1 invert_ref_input_b_out == $past(cfg_wdata_in[2], 2))
        else $error("ref b inversion mismatch");
    a_ref_a_invert: assert property (
        s_wr(7'h00) |=> ##1 invert_ref_input_a_out == $past(cfg_wdata_in[1], 2))
        else $error("ref a inversion mismatch");
    a_resistor_bits: assert property (
        s_wr(7'h4F) |=> ##1 loop_filter_resistor_out == {$past(cfg_wdata_in[15], 2),
        $past(cfg_wdata_in[12], 2), $past(cfg_wdata_in[11], 2), $past(cfg_wdata_in[8], 2)})
        else $error("resistor field mismatch");
    a_hf_cap_bits: assert property (
        s_wr(7'h4F) |=> ##1 loop_filter_hf_cap_out ==
        {$past(cfg_wdata_in[7], 2), $past(cfg_wdata_in[4], 2)})
        else $error("capacitor field mismatch");
    a_ready_one_cycle: assert property (
        cfg_ready_out == $past(cfg_en_in))
        else $error("answer strobe out of step with access strobe");
    a_loop_enable_bit: assert property (
        s_wr(7'h73) |=> ##1 loop_enable_out == $past(cfg_wdata_in[12], 2))
        else $error("loop enable mismatch");
    // ----------------------------------------------------------------
    // Start-up waits; seven cycles cover the four-flop synchronizer
    // ----------------------------------------------------------------
    a_release_starts_lock: assert property (
        (global_tristate_release_in && loop_enable_out) [*7] |-> lock_detect_start_out)
        else $error("lock detection not started");
    a_lock_ends_stall: assert property (
        lock_indicator_in [*7] |-> !startup_stall_out)
        else $error("stall held while lock_indicator");
    // ----------------------------------------------------------------
    // Fractional divider
    // ----------------------------------------------------------------
    a_frac_needs_enables: assert property (
        !(counter_enable_in && fractional_enable_in) |=> !frac_active_out && !frac_clk_out)
        else $error("fractional divider ran while disabled");
    a_frac_start_phase: assert property (
        $rose(frac_active_out) |-> phase_a_out == 3'h0 && phase_b_out == 3'h2)
        else $error("fractional start phases wrong");
    a_phase_b_steps: assert property (
        frac_active_out && $past(frac_active_out) && $changed(phase_b_out) |->
        $rose(frac_clk_out) && phase_b_out == $past(phase_b_out) + 3'h2)
        else $error("counter b phase step wrong");
endmodule // clock_synth_reconfig_regs_chk
bind clock_synth_reconfig_regs clock_synth_reconfig_regs_chk u_chk (.*);
`default_nettype wire

/* verif/clock_synth_reconfig_regs_tb_top.sv */
// Self-checking testbench of the clock synthesizer register bank
`timescale 1ns/100ps
`default_nettype none
module clock_synth_reconfig_regs_tb_top;
    logic clk_in = 1'b0, rstn_in = 1'b0, global_tristate_release_in = 1'b0;
    logic lock_indicator_in = 1'b0, counter_enable_in = 1'b0, fractional_enable_in = 1'b0;
    logic edge_a_in = 1'b0, edge_b_in = 1'b0;
    wire logic cfg_en_in, cfg_we_in, cfg_ready_out, invert_ref_input_a_out;
    wire logic invert_ref_input_b_out, invert_feedback_input_out, loop_enable_out;
    wire logic lock_detect_start_out, startup_stall_out, frac_clk_out, frac_active_out;
    wire logic [6:0]  cfg_addr_in;
    wire logic [15:0] cfg_wdata_in, cfg_rdata_out;
    wire logic [2:0]  spread_start_step_count_out, spread_step_count_out;
    wire logic [2:0]  phase_a_out, phase_b_out;
    wire logic [3:0]  loop_filter_resistor_out;
    wire logic [1:0]  loop_filter_hf_cap_out;
    wire logic [2:0]  inv_w = {invert_feedback_input_out, invert_ref_input_b_out,
                               invert_ref_input_a_out};
    wire logic [5:0]  spr_w = {spread_start_step_count_out, spread_step_count_out};
    integer bad_count = 0, compares = 0, i;
    int pos [6] = '{15, 12, 11, 8, 7, 4};
    logic [15:0] q;
    always #10 clk_in = ~clk_in;
    clock_synth_reconfig_regs u_dut (.*);
    fabric_cfg_master u_host (.clk_in(clk_in), .rdata_in(cfg_rdata_out),
        .ready_in(cfg_ready_out), .en_out(cfg_en_in), .we_out(cfg_we_in),
        .addr_out(cfg_addr_in), .wdata_out(cfg_wdata_in));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
        u_host.access(1'b0, a, 16'h0000, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        u_host.access(1'b1, a, d, q);
        @(negedge clk_in);
    endtask
    task automatic pulse(input logic b);
        @(posedge clk_in);
        if (b)
            edge_b_in <= 1'b1;
        else
            edge_a_in <= 1'b1;
        @(posedge clk_in);
        edge_a_in <= 1'b0;
        edge_b_in <= 1'b0;
        @(negedge clk_in);
    endtask
    task automatic wrap_up;
        bad_count += u_host.misses;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        #100000;
        bad_count++;
        wrap_up();
    end
    initial
    begin
        repeat (3) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (2) @(negedge clk_in);
        chk({loop_enable_out, spr_w}, 16'h67);
        rd_chk(7'h04, 16'h0027);
        rd_chk(7'h73, 16'h1000);
        rd_chk(7'h00, 16'h0000);
        wr(7'h10, 16'hFFFF);
        rd_chk(7'h10, 16'h0000);
        wr(7'h04, 16'hFFFF);
        rd_chk(7'h04, 16'h003F);
        for (i = 0; i < 2; i++)
        begin
            u_host.set_spread(i[0]);
            @(negedge clk_in);
            chk(spr_w, i[0] ? 16'h0027 : 16'h0023);
        end
        for (i = 1; i < 4; i++)
        begin
            wr(7'h00, 16'h0001 << i);
            chk(inv_w, 16'h0001 << (i - 1));
        end
        for (i = 0; i < 6; i++)
        begin
            wr(7'h4F, 16'h0001 << pos[i]);
            chk({loop_filter_resistor_out, loop_filter_hf_cap_out}, 16'h20 >> i);
        end
        wr(7'h4F, 16'hFFFF);
        rd_chk(7'h4F, 16'h9990);
        wr(7'h73, 16'hD000);
        repeat (8) @(negedge clk_in);
        chk({lock_detect_start_out, startup_stall_out}, 16'h1);
        @(posedge clk_in);
        global_tristate_release_in <= 1'b1;
        lock_indicator_in <= 1'b1;
        repeat (8) @(negedge clk_in);
        chk({lock_detect_start_out, startup_stall_out}, 16'h2);
        wr(7'h73, 16'h0000);
        chk({loop_enable_out, lock_detect_start_out, startup_stall_out}, 16'h0);
        @(posedge clk_in);
        counter_enable_in <= 1'b1;
        pulse(1'b0);
        chk({frac_active_out, frac_clk_out}, 16'h0);
        @(posedge clk_in);
        fractional_enable_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        pulse(1'b0);
        chk({frac_clk_out, phase_a_out, phase_b_out}, 16'h42);
        for (i = 0; i < 7; i++)
        begin
            pulse(1'b1);
            chk({frac_clk_out, phase_b_out}, {(i % 2) == 0, 3'(2 + 2 * (i / 2))});
        end
        @(posedge clk_in);
        counter_enable_in <= 1'b0;
        repeat (2) @(negedge clk_in);
        chk({frac_active_out, frac_clk_out}, 16'h0);
        wrap_up();
    end
endmodule // clock_synth_reconfig_regs_tb_top
`default_nettype wire

/* verif/fabric_cfg_master.sv */
// Fabric-side master model of the reconfiguration port
`timescale 1ns/100ps
`default_nettype none
module fabric_cfg_master
(
    input  wire logic        clk_in,
    input  wire logic [15:0] rdata_in,
    input  wire logic        ready_in,
    output logic             en_out,
    output logic             we_out,
    output logic [6:0]       addr_out,
    output logic [15:0]      wdata_out
);
    integer misses = 0;
    initial
    begin
        en_out = 1'b0;
        we_out = 1'b0;
        addr_out = 7'h00;
        wdata_out = 16'h0000;
    end
    // One-cycle strobe per access, then a bounded wait for the answer
    task automatic access(input logic we, input logic [6:0] a, input logic [15:0] d,
                          output logic [15:0] q);
        integer n;
        n = 0;
        @(posedge clk_in);
        en_out <= 1'b1;
        we_out <= we;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        en_out <= 1'b0;
        // Released data is scrambled so a stale word is never mistaken as held
        wdata_out <= ~d;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (ready_in !== 1'b1 && n < 8);
        if (ready_in !== 1'b1)
            misses++;
        q = rdata_in;
    endtask
    // Bits outside the mask keep the value read back
    task automatic rmw(input logic [6:0] a, input logic [15:0] mask, input logic [15:0] v);
        logic [15:0] q;
        access(1'b0, a, 16'h0000, q);
        access(1'b1, a, (q & ~mask) | (v & mask), q);
    endtask
    // Start count 100 always; step count 011 down-spread, 111 center-spread
    task automatic set_spread(input logic center);
        rmw(7'h04, 16'h003F, center ? 16'h0027 : 16'h0023);
    endtask
endmodule // fabric_cfg_master
`default_nettype wire
